// *** dv/mcu_model.sv ***
// Behavioural controller that drives the keying and data pins
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
    // Clocks
    input wire logic clk_i,
    input wire logic link_clk_i,
    // Bench controls
    input wire logic amp_level_i,
    input wire logic amp_toggle_i,
    input wire logic freq_level_i,
    input wire logic freq_float_i,
    input wire logic [15:0] pattern_i,
    // Device pins
    input wire logic data_clock_pin_i,
    input wire logic pullup_i,
    output logic amplitude_key_pin_o,
    output logic frequency_key_pin_o,
    output logic tx_data_pin_o
);
    logic baud_q = 1'b0; // Last seen baud level
    logic data_q = 1'b0; // Bit on the data pin
    logic [3:0] idx = 4'h0; // Next pattern bit
    // Change data on the falling baud edge so it is stable at the rise
    always @(posedge clk_i) begin
        baud_q <= data_clock_pin_i;
        if (baud_q && !data_clock_pin_i) begin
            data_q <= pattern_i[idx];
            idx <= idx + 4'h1;
        end
    end
    assign tx_data_pin_o = data_q;
    // Held high for frequency-only work, or toggled freely
    assign amplitude_key_pin_o = amp_toggle_i ? link_clk_i :
        amp_level_i;
    // A floating pin without pull-up wanders rather than holding a level
    assign frequency_key_pin_o = !freq_float_i ? freq_level_i :
        (pullup_i ? 1'b1 : link_clk_i);
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the transmit control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
    int errors = 0;
    int cmp_count = 0;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic resetn_i = 1'b0;
    // Register port
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    // Synthesizer and controller stimulus
    logic pll_phase_ok_i = 1'b0;
    logic amp_lvl = 1'b1;
    logic amp_tog = 1'b0;
    logic frq_flt = 1'b1;
    wire logic amplitude_key_pin_i, frequency_key_pin_i, tx_data_pin_i;
    // Design outputs
    logic key_pins_input_o, freq_key_pullup_o, data_clock_pin_o;
    logic general_output_pin_o, pll_run_o, rx_two_thirds_o;
    logic [23:0] pll_word_o;
    logic [7:0] deviation_o, amp_ref_code_o;
    logic freq_select_o, loop_filter_ext_o, pa_enable_o;
    logic [2:0] charge_pump_sel_o;
    logic amp_ref_gain2x_o, amp_ref_ground_o, pa_gate_ground_o;
    logic [15:0] q;
    int n;
    // Register rows: address, written word, word read back
    typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] r;} row_s;
    row_s rows [9] = '{'{4'h1, 16'hFF17, 16'h0017},
        '{4'h2, 16'hFF5A, 16'h015A},
        '{4'h3, 16'hFF12, 16'h0012}, '{4'h4, 16'h12AB, 16'h00AB},
        '{4'h5, 16'hCDEF, 16'hCDEF}, '{4'h6, 16'h000F, 16'h000F},
        '{4'h7, 16'hFFFE, 16'h0000}, '{4'hC, 16'hFFFF, 16'h0000},
        '{4'h0, 16'hFFC0, 16'h0000}};
    // Short window keeps the failure case quick
    tx_control_lock_detect #(.LOCK_WINDOW_CYC(200)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pll_phase_ok_i(pll_phase_ok_i),
        .amplitude_key_pin_i(amplitude_key_pin_i),
        .frequency_key_pin_i(frequency_key_pin_i),
        .tx_data_pin_i(tx_data_pin_i), .key_pins_input_o(key_pins_input_o),
        .freq_key_pullup_o(freq_key_pullup_o),
        .data_clock_pin_o(data_clock_pin_o),
        .general_output_pin_o(general_output_pin_o), .pll_run_o(pll_run_o),
        .rx_two_thirds_o(rx_two_thirds_o), .pll_word_o(pll_word_o),
        .deviation_o(deviation_o), .freq_select_o(freq_select_o),
        .loop_filter_ext_o(loop_filter_ext_o),
        .charge_pump_sel_o(charge_pump_sel_o), .pa_enable_o(pa_enable_o),
        .amp_ref_code_o(amp_ref_code_o), .amp_ref_gain2x_o(amp_ref_gain2x_o),
        .amp_ref_ground_o(amp_ref_ground_o),
        .pa_gate_ground_o(pa_gate_ground_o));
    mcu_model u_mcu (
        .clk_i(clk_i), .link_clk_i(link_clk), .amp_level_i(amp_lvl),
        .amp_toggle_i(amp_tog), .freq_level_i(1'b0), .freq_float_i(frq_flt),
        .pattern_i(16'hA5C3), .data_clock_pin_i(data_clock_pin_o),
        .pullup_i(freq_key_pullup_o),
        .amplitude_key_pin_o(amplitude_key_pin_i),
        .frequency_key_pin_o(frequency_key_pin_i),
        .tx_data_pin_o(tx_data_pin_i));
    // 200 MHz system clock and unrelated 48 ns keying clock
    always #2.5 clk_i = ~clk_i;
    always #24 link_clk = ~link_clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Bus cycles leave one idle cycle so a strobe never gets two values
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    // Bounded wait for a baud clock level
    task automatic wait_baud(input logic lvl);
        int i;
        for (i = 0; i < 500 && data_clock_pin_o !== lvl; i++) begin
            @(posedge clk_i);
        end
        if (i == 500) begin
            errors++;
            stop_test();
        end
    endtask
    task automatic chip_chk(input logic [7:0] dev, input logic c);
        if (dev == 8'h00) begin
            `CHK("ook pa", c, pa_enable_o)
            `CHK("ook fsel", 1'b0, freq_select_o)
        end else begin
            `CHK("fsk pa", 1'b1, pa_enable_o)
            `CHK("fsk fsel", c, freq_select_o)
        end
    endtask
    // Four baud periods; chip checked mid high half, and mid low half only with Manchester
    task automatic sync_run(input logic [7:0] dev, input logic man);
        logic b;
        wr(4'h3, {8'h00, dev});
        wr(4'h0, {13'h0000, man, 2'h3});
        for (int k = 0; k < 4; k++) begin
            wait_baud(1'b0);
            wait_baud(1'b1);
            b = tx_data_pin_i;
            repeat (8) @(posedge clk_i);
            chip_chk(dev, b);
            if (man) begin
                repeat (16) @(posedge clk_i);
                chip_chk(dev, ~b);
            end
        end
        wr(4'h0, 16'h0000);
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        `CHK("gnd rst", 1'b1, amp_ref_ground_o)
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], q);
            `CHK("reset val", 16'h0000, q)
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            `CHK("reg", rows[i].r, q)
        end
        `CHK("word", 24'hABCDEF, pll_word_o)
        `CHK("ext lf", 1'b1, loop_filter_ext_o)
        `CHK("cp", 3'h7, charge_pump_sel_o)
        `CHK("dev out", 8'h12, deviation_o)
        wr(4'h0, 16'h0001);
        repeat (4) @(posedge clk_i);
        `CHK("rx ratio", 1'b1, rx_two_thirds_o)
        `CHK("rx word", 24'hABCDEF + 24'h000999, pll_word_o)
        `CHK("rx gate", 1'b1, pa_gate_ground_o)
        // Async transmit before the synthesizer settles
        wr(4'h0, 16'h0012);
        repeat (20) @(posedge clk_i);
        `CHK("pa unlocked", 1'b0, pa_enable_o)
        `CHK("dcp unlocked", 1'b0, data_clock_pin_o)
        `CHK("float", 1'b1, freq_select_o)
        `CHK("key in", 1'b1, key_pins_input_o)
        pll_phase_ok_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        `CHK("pa locked", 1'b1, pa_enable_o)
        `CHK("dcp locked", 1'b1, data_clock_pin_o)
        `CHK("out lock", 1'b1, general_output_pin_o)
        `CHK("ref", 9'h15A, {amp_ref_gain2x_o, amp_ref_code_o})
        pll_phase_ok_i <= 1'b0;
        frq_flt <= 1'b0;
        repeat (30) @(posedge clk_i);
        `CHK("pa kept", 1'b1, pa_enable_o)
        `CHK("fsel low", 1'b0, freq_select_o)
        // Key held low long enough for the key assertion to engage
        amp_lvl <= 1'b0;
        repeat (20) @(posedge clk_i);
        `CHK("pa key low", 1'b0, pa_enable_o)
        amp_lvl <= 1'b1;
        amp_tog <= 1'b1;
        n = 0;
        q[0] = pa_enable_o;
        repeat (200) begin
            @(posedge clk_i);
            if (pa_enable_o !== q[0]) n++;
            q[0] = pa_enable_o;
        end
        `CHK("pa follows", 1'b1, n >= 10)
        amp_tog <= 1'b0;
        wr(4'h0, 16'h0000);
        // Window runs out with the synthesizer still unsettled
        wr(4'h0, 16'h0022);
        repeat (260) @(posedge clk_i);
        rd(4'h7, q);
        `CHK("fail status", 16'h0005, q)
        `CHK("out unlock", 1'b1, general_output_pin_o)
        wr(4'h7, 16'h0001);
        rd(4'h7, q);
        `CHK("flag clear", 16'h0004, q)
        pll_phase_ok_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        `CHK("pa failed", 1'b0, pa_enable_o)
        wr(4'h0, 16'h000A);
        repeat (30) @(posedge clk_i);
        `CHK("pa hold", 1'b1, pa_enable_o)
        wr(4'h0, 16'h0000);
        sync_run(8'h00, 1'b0);
        sync_run(8'h00, 1'b1);
        sync_run(8'h12, 1'b1);
        // Reset in the middle of a synchronous transfer
        wr(4'h0, 16'h0003);
        repeat (40) @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        `CHK("run rst", 1'b0, pll_run_o)
        `CHK("dcp rst", 1'b0, data_clock_pin_o)
        rd(4'h3, q);
        `CHK("dev rst", 16'h0000, q)
        stop_test();
    end
endmodule
`default_nettype wire

// *** dv/tx_ctrl_properties.sv ***
// Concurrent checks on the transmit control block ports
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_checker #(
    parameter int LOCK_WINDOW_CYC = 26000
) (
    // Clock, reset and register strobes
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    // Keying and synthesizer
    input wire logic amplitude_key_pin_i,
    input wire logic key_pins_input_o,
    input wire logic freq_key_pullup_o,
    input wire logic pll_run_o,
    input wire logic rx_two_thirds_o,
    input wire logic [23:0] pll_word_o,
    input wire logic [7:0] deviation_o,
    input wire logic freq_select_o,
    // Amplifier
    input wire logic pa_enable_o,
    input wire logic [7:0] amp_ref_code_o,
    input wire logic amp_ref_gain2x_o,
    input wire logic amp_ref_ground_o,
    input wire logic pa_gate_ground_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Transmitting with the baud clock: running, not receive, not async
    wire logic sync_tx = pll_run_o && !rx_two_thirds_o && !key_pins_input_o;
    // Read data only in the cycle after a read strobe
    a_read_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    // Mode edges may settle over two cycles, hence the short repetitions
    a_rx_ground: assert property (
        rx_two_thirds_o [*3] |-> !pa_enable_o && amp_ref_ground_o
        && pa_gate_ground_o && amp_ref_code_o == 8'h00)
        else $error("receive left amplifier live");
    a_idle_ground: assert property (
        !pll_run_o [*3] |->
        amp_ref_ground_o && pa_gate_ground_o && !pa_enable_o)
        else $error("idle left amplifier live");
    a_gain_tx: assert property (
        amp_ref_gain2x_o |-> !amp_ref_ground_o)
        else $error("gain buffer on while grounded");
    a_async_pins: assert property (
        key_pins_input_o |->
        freq_key_pullup_o && pll_run_o && !rx_two_thirds_o)
        else $error("async transmit setup wrong");
    a_rx_ratio: assert property (rx_two_thirds_o |-> pll_run_o)
        else $error("receive ratio without synthesizer");
    a_amp_key: assert property (
        (key_pins_input_o && !amplitude_key_pin_i) [*8]
        |=> !pa_enable_o)
        else $error("amplifier on with key low");
    a_ook_no_fsk: assert property (
        (sync_tx && deviation_o == 8'h00) [*3]
        |-> !freq_select_o)
        else $error("frequency keyed in on-off mode");
    a_word_cause: assert property (
        $changed(pll_word_o)
        |-> $past(wr_i) || $past(wr_i, 2))
        else $error("frequency word moved without write");
    // Main scenarios reached
    c_async_on: cover property (key_pins_input_o && pa_enable_o);
    c_sync_on: cover property (sync_tx && pa_enable_o);
    c_rx: cover property (rx_two_thirds_o);
endmodule
bind tx_control_lock_detect tx_ctrl_checker #(
    .LOCK_WINDOW_CYC(LOCK_WINDOW_CYC)
) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .amplitude_key_pin_i(amplitude_key_pin_i),
    .key_pins_input_o(key_pins_input_o),
    .freq_key_pullup_o(freq_key_pullup_o), .pll_run_o(pll_run_o),
    .rx_two_thirds_o(rx_two_thirds_o), .pll_word_o(pll_word_o),
    .deviation_o(deviation_o), .freq_select_o(freq_select_o),
    .pa_enable_o(pa_enable_o), .amp_ref_code_o(amp_ref_code_o),
    .amp_ref_gain2x_o(amp_ref_gain2x_o),
    .amp_ref_ground_o(amp_ref_ground_o),
    .pa_gate_ground_o(pa_gate_ground_o)
);
`default_nettype wire

// *** rtl/tx_control_lock_detect.sv ***
// Transmit control, lock detector, keying and baud clock logic
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_ctrl_params.svh"

// Pin synchroniser: a change counts once stages two and three agree
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pin and clean level
    input wire logic pin_i,
    output logic level_o
);
    logic q1; // Only read by q2
    logic q2;
    logic q3;

    // Three stage capture with agreement filter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q1 <= RST_VAL;
            q2 <= RST_VAL;
            q3 <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            q1 <= pin_i;
            q2 <= q1;
            q3 <= q2;
            if (q2 == q3) begin
                level_o <= q3;
            end
        end
    end
endmodule

module tx_control_lock_detect #(
    // Lock window in cycles; shorten in simulation
    parameter int LOCK_WINDOW_CYC = `LOCK_WINDOW_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Synthesizer lock indication and keying pins
    input wire logic pll_phase_ok_i,
    input wire logic amplitude_key_pin_i,
    input wire logic frequency_key_pin_i,
    input wire logic tx_data_pin_i,
    // Pin direction and pull-up control
    output logic key_pins_input_o,
    output logic freq_key_pullup_o,
    // Data clock and general output pins
    output logic data_clock_pin_o,
    output logic general_output_pin_o,
    // Synthesizer control
    output logic pll_run_o,
    output logic rx_two_thirds_o,
    output logic [23:0] pll_word_o,
    output logic [7:0] deviation_o,
    output logic freq_select_o,
    output logic loop_filter_ext_o,
    output logic [2:0] charge_pump_sel_o,
    // Amplifier control
    output logic pa_enable_o,
    output logic [7:0] amp_ref_code_o,
    output logic amp_ref_gain2x_o,
    output logic amp_ref_ground_o,
    output logic pa_gate_ground_o
);
    // Software registers
    logic [5:0] mode_reg; // Mode, line code, hold, output select
    logic [4:0] trim_reg; // Synthesizer trim register
    logic [8:0] ampref_reg; // DAC code and gain select
    logic [7:0] dev_reg; // Peak deviation
    logic [7:0] fint_reg; // Integer part
    logic [15:0] ffrac_reg; // Fraction part
    logic [15:0] baud_reg; // Half baud period minus one

    // Status
    logic pll_unlocked_flag; // Sticky, write one to clear
    logic lock_fail; // Window ran out
    tx_ctrl_pkg::lock_state_e ld_state;
    tx_ctrl_pkg::lock_state_e next_ld_state;
    logic [15:0] win_cnt; // Cycles spent in the lock window
    logic [7:0] settle_cnt; // Consecutive good lock samples

    // Clean pin levels
    logic phase_ok;
    logic amp_key;
    logic freq_key;
    logic tx_data;

    // Baud clock generator
    logic [15:0] baud_cnt;
    logic data_clock_pin; // Baud clock level
    logic tx_bit; // Bit taken at the rising baud edge

    // Decode
    wire logic [1:0] op_mode = mode_reg[`MODE_MSB:`MODE_LSB];
    wire logic manch_en = mode_reg[`MODE_MANCH_BIT];
    wire logic lock_hold = mode_reg[`MODE_HOLD_BIT];
    wire logic [1:0] gpo_sel = mode_reg[`MODE_GPO_MSB:`MODE_GPO_LSB];
    wire logic in_rx = (op_mode == `OP_RX);
    wire logic in_atx = (op_mode == `OP_ATX);
    wire logic in_stx = (op_mode == `OP_STX);
    wire logic in_tx = in_atx | in_stx;
    wire logic dev_zero = (dev_reg == 8'h00);
    wire logic locked = (ld_state == tx_ctrl_pkg::LD_LOCKED);
    // Gate for the amplifier; the hold bit overrides it
    wire logic pa_gate = locked | lock_hold;
    wire logic win_end =
        (win_cnt >= 16'(LOCK_WINDOW_CYC - 1));
    wire logic settled =
        (settle_cnt >= `LOCK_SETTLE_CYC - 8'h01);
    wire logic baud_run = in_stx & pa_gate;
    wire logic baud_tick = (baud_cnt >= baud_reg);
    wire logic baud_rise = baud_run & baud_tick & ~data_clock_pin;
    // Unlock seen: window ran out, or lost lock while held
    wire logic unlock_evt =
        ((ld_state == tx_ctrl_pkg::LD_WAIT) & win_end & ~phase_ok)
        | (locked & lock_hold & ~phase_ok);
    wire logic status_wr = wr_i & (addr_i == `REG_STATUS);
    wire logic clr_unlock = status_wr & wdata_i[`ST_UNLOCK_BIT];

    // Modulation data: Manchester halves follow the baud clock
    wire logic sync_chip =
        manch_en ? (data_clock_pin ? tx_bit : ~tx_bit) : tx_bit;

    // Keying decisions
    wire logic next_pa =
        in_atx ? (amp_key & pa_gate) :
        in_stx ? (pa_gate & (dev_zero ? sync_chip : 1'b1)) :
        1'b0;
    // Only one keying in sync mode: FSK only when deviation set
    wire logic next_fsel =
        in_atx ? freq_key :
        in_stx ? (~dev_zero & sync_chip) :
        1'b0;
    wire logic next_data_clock_pin_pin =
        in_atx ? locked :
        in_stx ? data_clock_pin :
        1'b0;
    wire logic next_gpo =
        (gpo_sel == `GPO_LOCK) ? locked :
        (gpo_sel == `GPO_UNLOCK) ? pll_unlocked_flag :
        (gpo_sel == `GPO_DATA_CLOCK_PIN) ? next_data_clock_pin_pin :
        1'b0;
    // Receive reuses integer and fraction; offset added here
    wire logic [23:0] base_word = {fint_reg, ffrac_reg};
    wire logic [23:0] next_word =
        in_rx ? 24'(base_word + `RX_OFFSET_CODE) :
        base_word;

    // Read mux
    wire logic [15:0] status_word = {13'h0000, lock_fail, locked,
        pll_unlocked_flag};
    wire logic [15:0] rd_mux =
        (addr_i == `REG_MODE) ? {10'h000, mode_reg} :
        (addr_i == `REG_TRIM) ? {11'h000, trim_reg} :
        (addr_i == `REG_AMPREF) ? {7'h00, ampref_reg} :
        (addr_i == `REG_DEV) ? {8'h00, dev_reg} :
        (addr_i == `REG_FINT) ? {8'h00, fint_reg} :
        (addr_i == `REG_FFRAC) ? ffrac_reg :
        (addr_i == `REG_BAUD) ? baud_reg :
        (addr_i == `REG_STATUS) ? status_word :
        16'h0000;

    // Pin synchronisers
    pin_sync #(.RST_VAL(1'b0)) u_sync_lock (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pll_phase_ok_i),
        .level_o(phase_ok)
    );
    pin_sync #(.RST_VAL(1'b0)) u_sync_amp (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(amplitude_key_pin_i),
        .level_o(amp_key)
    );
    // Frequency pin rests high like its pull-up
    pin_sync #(.RST_VAL(1'b1)) u_sync_freq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(frequency_key_pin_i),
        .level_o(freq_key)
    );
    pin_sync #(.RST_VAL(1'b0)) u_sync_data (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(tx_data_pin_i),
        .level_o(tx_data)
    );

    // Register writes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg <= `RST_MODE;
            trim_reg <= `RST_TRIM;
            ampref_reg <= `RST_AMPREF;
            dev_reg <= `RST_DEV;
            fint_reg <= `RST_FINT;
            ffrac_reg <= `RST_FFRAC;
            baud_reg <= `RST_BAUD;
        end else if (wr_i) begin
            unique case (addr_i)
                `REG_MODE: mode_reg <= wdata_i[5:0];
                `REG_TRIM: trim_reg <= wdata_i[4:0];
                `REG_AMPREF: ampref_reg <= wdata_i[8:0];
                `REG_DEV: dev_reg <= wdata_i[7:0];
                `REG_FINT: fint_reg <= wdata_i[7:0];
                `REG_FFRAC: ffrac_reg <= wdata_i;
                `REG_BAUD: baud_reg <= wdata_i;
                default: ; // Status and unmapped: no storage
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end

    // Lock detector next state
    always_comb begin
        next_ld_state = ld_state;
        unique case (ld_state)
            tx_ctrl_pkg::LD_IDLE: begin
                // Each entry into transmit starts a fresh window
                if (in_tx) begin
                    next_ld_state = tx_ctrl_pkg::LD_WAIT;
                end
            end
            tx_ctrl_pkg::LD_WAIT: begin
                if (settled & phase_ok) begin
                    next_ld_state = tx_ctrl_pkg::LD_LOCKED;
                end else if (win_end) begin
                    // Too slow a loop: give up; without hold the amplifier stays off
                    next_ld_state = tx_ctrl_pkg::LD_FAIL;
                end
            end
            tx_ctrl_pkg::LD_LOCKED: begin
                // Without hold the detector stops here
                if (lock_hold & ~phase_ok) begin
                    next_ld_state = tx_ctrl_pkg::LD_WAIT;
                end
            end
            tx_ctrl_pkg::LD_FAIL: begin
                // Hold keeps the detector trying
                if (lock_hold) begin
                    next_ld_state = tx_ctrl_pkg::LD_WAIT;
                end
            end
            default: next_ld_state = tx_ctrl_pkg::LD_IDLE;
        endcase
        if (!in_tx) begin
            next_ld_state = tx_ctrl_pkg::LD_IDLE;
        end
    end

    // Lock detector state and counters
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ld_state <= tx_ctrl_pkg::LD_IDLE;
            win_cnt <= 16'h0000;
            settle_cnt <= 8'h00;
        end else begin
            ld_state <= next_ld_state;
            if (ld_state != tx_ctrl_pkg::LD_WAIT) begin
                win_cnt <= 16'h0000;
            end else if (!win_end) begin
                win_cnt <= win_cnt + 16'h0001;
            end
            // A single bad sample restarts the settle count
            if (!phase_ok || ld_state != tx_ctrl_pkg::LD_WAIT) begin
                settle_cnt <= 8'h00;
            end else if (!settled) begin
                settle_cnt <= settle_cnt + 8'h01;
            end
        end
    end

    // Status flags; a new unlock wins over a clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pll_unlocked_flag <= 1'b0;
            lock_fail <= 1'b0;
        end else begin
            if (unlock_evt) begin
                pll_unlocked_flag <= 1'b1;
            end else if (clr_unlock) begin
                pll_unlocked_flag <= 1'b0;
            end
            lock_fail <= (ld_state == tx_ctrl_pkg::LD_FAIL);
        end
    end

    // Baud clock: runs in sync transmit once the gate opens
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            baud_cnt <= 16'h0000;
            data_clock_pin <= 1'b0;
            tx_bit <= 1'b0;
        end else if (!baud_run) begin
            baud_cnt <= 16'h0000;
            data_clock_pin <= 1'b0;
        end else if (baud_tick) begin
            baud_cnt <= 16'h0000;
            data_clock_pin <= ~data_clock_pin;
            if (baud_rise) begin
                // Controller changes data away from this edge
                tx_bit <= tx_data;
            end
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_pins_input_o <= 1'b0;
            freq_key_pullup_o <= 1'b0;
            data_clock_pin_o <= 1'b0;
            general_output_pin_o <= 1'b0;
            pll_run_o <= 1'b0;
            rx_two_thirds_o <= 1'b0;
            pll_word_o <= 24'h000000;
            deviation_o <= 8'h00;
            freq_select_o <= 1'b0;
            loop_filter_ext_o <= 1'b0;
            charge_pump_sel_o <= 3'h0;
            pa_enable_o <= 1'b0;
            amp_ref_code_o <= 8'h00;
            amp_ref_gain2x_o <= 1'b0;
            amp_ref_ground_o <= 1'b1;
            pa_gate_ground_o <= 1'b1;
        end else begin
            key_pins_input_o <= in_atx;
            freq_key_pullup_o <= in_atx;
            data_clock_pin_o <= next_data_clock_pin_pin;
            general_output_pin_o <= next_gpo;
            pll_run_o <= in_tx | in_rx;
            rx_two_thirds_o <= in_rx;
            pll_word_o <= next_word;
            deviation_o <= dev_reg;
            freq_select_o <= next_fsel;
            loop_filter_ext_o <= trim_reg[`TRIM_EXTLF_BIT];
            charge_pump_sel_o <=
                trim_reg[`TRIM_CP_MSB:`TRIM_CP_LSB];
            pa_enable_o <= next_pa;
            // Reference pin and gate grounded outside transmit
            amp_ref_code_o <= in_tx ? ampref_reg[7:0] : 8'h00;
            amp_ref_gain2x_o <=
                in_tx & ampref_reg[`AMP_GAIN_BIT];
            amp_ref_ground_o <= ~in_tx;
            pa_gate_ground_o <= ~in_tx;
        end
    end
endmodule
`default_nettype wire

// *** rtl/tx_ctrl_params.svh ***
// Constants of the transmit control and lock detect block
`ifndef TX_CTRL_PARAMS_SVH
`define TX_CTRL_PARAMS_SVH

// Register addresses
`define REG_MODE 4'h0
`define REG_TRIM 4'h1
`define REG_AMPREF 4'h2
`define REG_DEV 4'h3
`define REG_FINT 4'h4
`define REG_FFRAC 4'h5
`define REG_BAUD 4'h6
`define REG_STATUS 4'h7

// Mode register fields
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_MANCH_BIT 2
`define MODE_HOLD_BIT 3
`define MODE_GPO_LSB 4
`define MODE_GPO_MSB 5

// Operating mode codes
`define OP_IDLE 2'h0
`define OP_RX 2'h1
`define OP_ATX 2'h2
`define OP_STX 2'h3

// General output pin selections
`define GPO_LOW 2'h0
`define GPO_LOCK 2'h1
`define GPO_UNLOCK 2'h2
`define GPO_DATA_CLOCK_PIN 2'h3

// Trim register fields
`define TRIM_EXTLF_BIT 4
`define TRIM_CP_LSB 0
`define TRIM_CP_MSB 2

// Amplifier reference register fields
`define AMP_GAIN_BIT 8

// Status register fields
`define ST_UNLOCK_BIT 0
`define ST_LOCK_BIT 1
`define ST_FAIL_BIT 2

// Reset values
`define RST_MODE 6'h00
`define RST_TRIM 5'h00
`define RST_AMPREF 9'h000
`define RST_DEV 8'h00
`define RST_FINT 8'h00
`define RST_FFRAC 16'h0000
`define RST_BAUD 16'h0000

// Receive offset in fraction codes (500 kHz at 20 MHz crystal x 2/3)
`define RX_OFFSET_CODE 24'h000999

// Timing
`define CLK_PERIOD_NS 5
`define LOCK_WINDOW_NS 130000
`define LOCK_SETTLE_NS 80
`define LOCK_SETTLE_CYC 8'((`LOCK_SETTLE_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)

`endif

// *** rtl/tx_ctrl_pkg.sv ***
// Types shared by the transmit control block
package tx_ctrl_pkg;
    // Lock detector states
    typedef enum logic [3:0] {
        LD_IDLE = 4'h1,
        LD_WAIT = 4'h2,
        LD_LOCKED = 4'h4,
        LD_FAIL = 4'h8
    } lock_state_e;
endpackage
